/* wdp_pkg.sv */
// constants and bus carriers for the write-protected watchdog
// assumes an apb master on the same clock, reset synchronous high
// Notes on behaviour
// - mode top bits 011; else ignored if locked
// - mode written once; second write resets
// - bit access never updates mode register
// - wrong key to service register resets
// - bit access to service register resets
// - locked oscillator keeps counting in stop
// - stoppable oscillator pauses, keeps count in standby
package wdp_pkg;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_MODE = 8'h00;  // watchdog_mode_register
  localparam logic [7:0] OFS_KEY  = 8'h04;  // watchdog_enable_clear_register
  localparam logic [7:0] OFS_STAT = 8'h08;  // sticky event status, w1c
  localparam logic [7:0] OFS_MASK = 8'h0c;  // event mask
  localparam logic [7:0] OFS_CNT  = 8'h10;  // live counter, read only

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam logic [7:0] MODE_RST = 8'h67;  // fixed bits 011, longest period
  localparam int         FIX_LSB  = 5;      // fixed bits sit at 7:5
  localparam logic [2:0] FIX_VAL  = 3'h3;   // required pattern 0,1,1
  localparam int         SEL_W    = 3;      // overflow select width, bits 2:0
  localparam logic [7:0] KEY_VAL  = 8'hac;  // service key
  localparam int         EV_W     = 3;      // number of events
  localparam int         EV_SVC   = 0;      // key accepted
  localparam int         EV_LOCK  = 1;      // mode register locked
  localparam int         EV_HALF  = 2;      // counter passed half period
  localparam logic [EV_W-1:0] MASK_RST = 3'h0;  // all events masked

  // ****************************************
  // bus carriers
  // ****************************************
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } wdp_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } wdp_rsp_s;

endpackage

/* wdp_top.sv */
// write-protected watchdog with apb register access
// assumes apb master on clk; osc_tick is a one-cycle pulse per slow clock
// bit_access qualifies a write as a single-bit manipulation
`timescale 1ns/1ps

module wdp_top #(
  parameter int CNT_W    = 20,  // counter width
  parameter int OVF_BASE = 10   // shortest period is 2**OVF_BASE ticks
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire wdp_pkg::wdp_req_s apb_req,
  output wdp_pkg::wdp_rsp_s      apb_rsp,
  input  wire logic             bit_access,
  input  wire logic             osc_locked,
  input  wire logic             standby_halt,
  input  wire logic             standby_stop,
  input  wire logic             osc_tick,
  output logic                  irq,
  output logic                  wdt_reset
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (CNT_W < OVF_BASE + 8 || CNT_W > 31 || OVF_BASE < 1) begin : g_bad
    $error("counter width cannot hold the longest period");
  end

  // ****************************************
  // state of the block
  // ****************************************
  typedef struct packed {
    wdp_pkg::wdp_rsp_s      rsp;        // bus answer
    logic [7:0]             mode;       // mode register contents
    logic                   mode_done;  // one write already taken
    logic [CNT_W-1:0]       cnt;        // watchdog counter
    logic [wdp_pkg::EV_W-1:0] stat;     // sticky events
    logic [wdp_pkg::EV_W-1:0] mask;     // event enables
    logic                   irq;        // level interrupt
    logic                   rst_out;    // internal reset pulse
  } wdp_state_s;

  localparam wdp_state_s ST_RST = '{
    rsp:       '0,
    mode:      wdp_pkg::MODE_RST,
    mode_done: 1'b0,
    cnt:       '0,
    stat:      '0,
    mask:      wdp_pkg::MASK_RST,
    irq:       1'b0,
    rst_out:   1'b0
  };

  wdp_state_s s_ff;   // registered state
  wdp_state_s nxt_s;  // next state

  // ****************************************
  // helpers
  // ****************************************
  // terminal count for an overflow select
  function automatic logic [CNT_W-1:0] ovf_limit(input logic [wdp_pkg::SEL_W-1:0] sel);
    logic [CNT_W:0] one;
    one = '0;
    one[0] = 1'b1;
    return CNT_W'((one << (OVF_BASE + int'(sel))) - 1'b1);
  endfunction

  // true for a mapped register offset
  function automatic logic is_mapped(input logic [7:0] a);
    return a == wdp_pkg::OFS_MODE || a == wdp_pkg::OFS_KEY ||
           a == wdp_pkg::OFS_STAT || a == wdp_pkg::OFS_MASK ||
           a == wdp_pkg::OFS_CNT;
  endfunction

  // ****************************************
  // decode of the current access
  // ****************************************
  logic             acc_done;  // access phase completes this edge
  logic             wr_done;   // write takes effect this edge
  logic             wr_mode;   // write to the mode register
  logic             wr_key;    // write to the service register
  logic             key_bad;   // service write that must reset
  logic             cnt_run;   // counter advances this edge
  logic [CNT_W-1:0] limit;     // terminal count now selected

  // fixed-field low bit, kept local so part-selects stay short
  localparam int    FIX_LSB_U = wdp_pkg::FIX_LSB;

  // the second access cycle, with pready up, is where a write lands
  assign acc_done = apb_req.psel & apb_req.penable & s_ff.rsp.pready;
  assign wr_done  = acc_done & apb_req.pwrite;
  assign wr_mode  = wr_done & (apb_req.paddr == wdp_pkg::OFS_MODE);
  assign wr_key   = wr_done & (apb_req.paddr == wdp_pkg::OFS_KEY);
  // a bit access resets even when it happens to carry the key
  assign key_bad  = bit_access | (apb_req.pwdata[7:0] != wdp_pkg::KEY_VAL);
  assign limit    = ovf_limit(s_ff.mode[wdp_pkg::SEL_W-1:0]);
  // locked oscillator never pauses; stoppable one pauses in standby
  assign cnt_run  = osc_tick & (osc_locked | ~(standby_halt | standby_stop));

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    logic [wdp_pkg::EV_W-1:0] ev;
    logic [31:0]              rd;
    ev = '0;
    rd = '0;
    nxt_s = s_ff;
    // pulses drop back to zero unless set again below
    nxt_s.rsp.pready = 1'b0;
    nxt_s.rst_out = 1'b0;
    // read mux, narrow registers sit in the low bits
    unique case (apb_req.paddr)
      wdp_pkg::OFS_MODE: rd[7:0] = s_ff.mode;
      wdp_pkg::OFS_STAT: rd[wdp_pkg::EV_W-1:0] = s_ff.stat;
      wdp_pkg::OFS_MASK: rd[wdp_pkg::EV_W-1:0] = s_ff.mask;
      wdp_pkg::OFS_CNT:  rd[CNT_W-1:0] = s_ff.cnt;
      default:           rd = '0;
    endcase
    // one wait cycle, then the answer from flip-flops
    if (apb_req.psel & apb_req.penable & ~s_ff.rsp.pready) begin
      nxt_s.rsp.pready  = 1'b1;
      nxt_s.rsp.pslverr = ~is_mapped(apb_req.paddr);
      nxt_s.rsp.prdata  = apb_req.pwrite ? 32'h0 : rd;
    end
    // counting and overflow
    if (cnt_run) begin
      if (s_ff.cnt == limit) begin
        nxt_s.rst_out = 1'b1;
        nxt_s.cnt = '0;
      end else begin
        nxt_s.cnt = s_ff.cnt + 1'b1;
      end
      if (s_ff.cnt == (limit >> 1)) begin
        ev[wdp_pkg::EV_HALF] = 1'b1;
      end
    end
    // mode register: one byte write after reset
    if (wr_mode) begin
      if (bit_access) begin
        nxt_s.mode = s_ff.mode;
      end else if (s_ff.mode_done) begin
        nxt_s.rst_out = 1'b1;
      end else if (osc_locked &&
                   apb_req.pwdata[7:FIX_LSB_U] != wdp_pkg::FIX_VAL) begin
        nxt_s.mode = s_ff.mode;
      end else begin
        nxt_s.mode = apb_req.pwdata[7:0];
        nxt_s.mode_done = 1'b1;
        ev[wdp_pkg::EV_LOCK] = 1'b1;
      end
    end
    // service register: key clears, anything else resets
    if (wr_key) begin
      if (key_bad) begin
        nxt_s.rst_out = 1'b1;
      end else begin
        nxt_s.cnt = '0;
        // a same-cycle overflow tick loses to the key
        nxt_s.rst_out = 1'b0;
        ev[wdp_pkg::EV_SVC] = 1'b1;
      end
    end
    // status clear by writing ones
    if (wr_done && apb_req.paddr == wdp_pkg::OFS_STAT) begin
      nxt_s.stat = s_ff.stat & ~apb_req.pwdata[wdp_pkg::EV_W-1:0];
    end
    // mask register
    if (wr_done && apb_req.paddr == wdp_pkg::OFS_MASK) begin
      nxt_s.mask = apb_req.pwdata[wdp_pkg::EV_W-1:0];
    end
    // a new event wins over a clear in the same cycle
    nxt_s.stat = nxt_s.stat | ev;
    nxt_s.irq = |(nxt_s.stat & nxt_s.mask);
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      s_ff <= ST_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ****************************************
  // outputs straight from flip-flops
  // ****************************************
  assign apb_rsp   = s_ff.rsp;
  assign irq       = s_ff.irq;
  assign wdt_reset = s_ff.rst_out;

  // ****************************************
  // checks
  // ****************************************
  // any value but the key on the service register must pull the reset
  chk_key_wrong: assert property (@(posedge clk) disable iff (reset)
    wr_key && apb_req.pwdata[7:0] != wdp_pkg::KEY_VAL |=> wdt_reset)
    else $error("wrong key did not reset");

  // a bit access resets whatever value it carries
  chk_key_bitop: assert property (@(posedge clk) disable iff (reset)
    wr_key && bit_access |=> wdt_reset && s_ff.cnt != '0 || wdt_reset)
    else $error("bit access to service register did not reset");

  // the key restarts counting from zero without a reset pulse
  chk_key_clear: assert property (@(posedge clk) disable iff (reset)
    wr_key && !key_bad |=> s_ff.cnt == '0 && !wdt_reset ##1 s_ff.cnt <= CNT_W'(1))
    else $error("service key did not clear counter");

  // a second mode write resets and leaves the register alone
  chk_mode_second: assert property (@(posedge clk) disable iff (reset)
    wr_mode && !bit_access && s_ff.mode_done |=> wdt_reset && $stable(s_ff.mode))
    else $error("second mode write not punished");

  // a bit access never touches the mode register or its lock
  chk_mode_bitop: assert property (@(posedge clk) disable iff (reset)
    wr_mode && bit_access |=> $stable(s_ff.mode) && $stable(s_ff.mode_done))
    else $error("bit access changed mode register");

  // with the oscillator locked, bad fixed bits leave mode and lock unchanged
  chk_mode_fixed: assert property (@(posedge clk) disable iff (reset)
    wr_mode && !bit_access && !s_ff.mode_done && osc_locked &&
    apb_req.pwdata[7:FIX_LSB_U] != wdp_pkg::FIX_VAL
    |=> $stable(s_ff.mode) && !s_ff.mode_done)
    else $error("bad fixed bits were taken");

  // a locked oscillator keeps the count running through stop
  chk_stop_runs: assert property (@(posedge clk) disable iff (reset)
    osc_locked && standby_stop && osc_tick && s_ff.cnt != limit && !wr_key
    |=> s_ff.cnt == $past(s_ff.cnt) + 1'b1)
    else $error("counter stalled in stop with locked oscillator");

  // overflow gives a single-cycle reset request
  chk_ovf_reset: assert property (@(posedge clk) disable iff (reset)
    cnt_run && s_ff.cnt == limit && !wr_key |=> wdt_reset ##1 !wdt_reset)
    else $error("overflow did not pulse reset");

  // a stoppable oscillator freezes the count in halt and stop
  chk_standby_hold: assert property (@(posedge clk) disable iff (reset)
    !osc_locked && (standby_halt || standby_stop) && !wr_key |=> $stable(s_ff.cnt))
    else $error("counter moved in standby");

  // ****************************************
  // bus, mode lock, counter, status and interrupt checks
  // ****************************************
  // every access phase is answered after exactly one wait cycle
  chk_bus_answer: assert property (@(posedge clk) disable iff (reset)
    apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready)
    else $error("access phase not answered");

  // the answer stands one cycle so a back-to-back setup is not acked twice
  chk_ready_pulse: assert property (@(posedge clk) disable iff (reset)
    apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready stood longer than one cycle");

  // unmapped offsets answer with the error flag
  chk_bus_error: assert property (@(posedge clk) disable iff (reset)
    apb_req.psel && apb_req.penable && !apb_rsp.pready && !is_mapped(apb_req.paddr)
    |=> apb_rsp.pslverr)
    else $error("unmapped access without error");

  // writes return zero data so nothing stale leaks onto the bus
  chk_write_data: assert property (@(posedge clk) disable iff (reset)
    apb_req.psel && apb_req.penable && !apb_rsp.pready && apb_req.pwrite
    |=> apb_rsp.prdata == 32'h0)
    else $error("write answered with data");

  // a good first mode write is stored and locks the register
  chk_mode_lock: assert property (@(posedge clk) disable iff (reset)
    wr_mode && !bit_access && !s_ff.mode_done &&
    (!osc_locked || apb_req.pwdata[7:FIX_LSB_U] == wdp_pkg::FIX_VAL)
    |=> s_ff.mode_done && s_ff.mode == $past(apb_req.pwdata[7:0]))
    else $error("first mode write not taken");

  // the counter only moves on a counting tick or a service write
  chk_cnt_idle: assert property (@(posedge clk) disable iff (reset)
    !cnt_run && !wr_key |=> $stable(s_ff.cnt))
    else $error("counter moved without a tick");

  // status bits are sticky until software writes ones to them
  chk_stat_sticky: assert property (@(posedge clk) disable iff (reset)
    !(wr_done && apb_req.paddr == wdp_pkg::OFS_STAT)
    |=> (s_ff.stat & $past(s_ff.stat)) == $past(s_ff.stat))
    else $error("status bit dropped without a clear");

  // a half-period tick raises its status bit even against a clear
  chk_half_event: assert property (@(posedge clk) disable iff (reset)
    cnt_run && s_ff.cnt == (limit >> 1) |=> s_ff.stat[wdp_pkg::EV_HALF])
    else $error("half period event lost");

  // an accepted key raises its status bit
  chk_svc_event: assert property (@(posedge clk) disable iff (reset)
    wr_key && !key_bad |=> s_ff.stat[wdp_pkg::EV_SVC])
    else $error("service event lost");

  // the interrupt level tracks unmasked status in the same cycle
  chk_irq_level: assert property (@(posedge clk) disable iff (reset)
    irq == |(s_ff.stat & s_ff.mask))
    else $error("interrupt level disagrees with status");

endmodule // wdp_top

/* wdp_top_tb_top.sv */
// bench for the write-protected watchdog: bus access, service key, standby counts
// assumes wdp_pkg and wdp_top compiled first; one clock, reset synchronous high
`timescale 1ns/1ps

module wdp_top_tb_top;
  // ****************************************
  // signals
  // ****************************************
  logic              clk        = 1'b0;  // 100 mhz clock
  logic              reset      = 1'b1;  // synchronous reset
  wdp_pkg::wdp_req_s req        = '0;    // apb request
  wdp_pkg::wdp_rsp_s rsp;                // apb answer
  logic              bit_access = 1'b0;  // single-bit access marker
  logic              osc_locked = 1'b1;  // oscillator cannot stop
  logic              halt       = 1'b0;  // halt standby
  logic              stop       = 1'b0;  // stop standby
  logic              tick       = 1'b0;  // slow oscillator pulse
  logic              irq;                // interrupt level
  logic              wdt_reset;          // internal reset request
  int                fails      = 0;     // mismatch count
  int                checked    = 0;     // comparison count
  logic [31:0]       rd;                 // last read data
  logic              err;                // last slave error
  logic [7:0]        k;                  // random tick count, later a random wrong key

  // clock generator
  always #5 clk = ~clk;

  wdp_top #(.CNT_W(10), .OVF_BASE(2)) i_dut (
    .clk(clk), .reset(reset), .apb_req(req), .apb_rsp(rsp), .bit_access(bit_access),
    .osc_locked(osc_locked), .standby_halt(halt), .standby_stop(stop),
    .osc_tick(tick), .irq(irq), .wdt_reset(wdt_reset));

  // ****************************************
  // tasks and functions
  // ****************************************
  // terminal count for a select value with base 2
  function automatic int term_cnt(input int sel);
    return (1 << (2 + sel)) - 1;
  endfunction

  // verdict and end of run
  task automatic print_verdict();
    if (fails == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic b);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    bit_access <= b;
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    bit_access <= 1'b0;
    if (n >= 20) begin
      fails++;
      print_verdict();
    end
  endtask

  // read and compare
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(rd, exp);
  endtask

  // count internal reset pulses over four cycles
  task automatic wd(input int exp);
    int c;
    c = 0;
    repeat (4) begin
      @(posedge clk);
      if (wdt_reset === 1'b1) c++;
    end
    chk(c, exp);
  endtask

  // slow oscillator pulses, one cycle high each
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(41137));
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rdchk(wdp_pkg::OFS_MODE, 32'h67);
    chk(err, 1'b0);
    rdchk(wdp_pkg::OFS_KEY, 32'h0);
    rdchk(8'h20, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, wdp_pkg::OFS_MODE, 32'h60, 1'b1);
    wd(0);
    rdchk(wdp_pkg::OFS_MODE, 32'h67);
    apb(1'b1, wdp_pkg::OFS_MODE, 32'h40, 1'b0);
    wd(0);
    rdchk(wdp_pkg::OFS_MODE, 32'h67);
    apb(1'b1, wdp_pkg::OFS_MODE, 32'h60, 1'b0);
    wd(0);
    rdchk(wdp_pkg::OFS_MODE, 32'h60);
    rdchk(wdp_pkg::OFS_STAT, 32'h2);
    // interrupt raised by unmasking, dropped by w1c
    apb(1'b1, wdp_pkg::OFS_MASK, 32'h2, 1'b0);
    @(posedge clk);
    chk(irq, 1'b1);
    apb(1'b1, wdp_pkg::OFS_STAT, 32'h2, 1'b0);
    @(posedge clk);
    chk(irq, 1'b0);
    k = 8'(1 + $urandom % 3);
    ticks(k);
    rdchk(wdp_pkg::OFS_CNT, {24'h0, k});
    apb(1'b1, wdp_pkg::OFS_KEY, 32'hac, 1'b0);
    wd(0);
    rdchk(wdp_pkg::OFS_CNT, 32'h0);
    // key accepted; half period passed only if a second tick came
    rdchk(wdp_pkg::OFS_STAT, {29'h0, k >= 8'd2, 2'b01});
    // stoppable oscillator pauses in halt and keeps its count
    osc_locked <= 1'b0;
    ticks(2);
    halt <= 1'b1;
    ticks(2);
    rdchk(wdp_pkg::OFS_CNT, 32'h2);
    halt <= 1'b0;
    ticks(1);
    rdchk(wdp_pkg::OFS_CNT, 32'h3);
    apb(1'b1, wdp_pkg::OFS_KEY, 32'hac, 1'b0);
    // locked oscillator counts in stop up to overflow
    osc_locked <= 1'b1;
    stop <= 1'b1;
    ticks(term_cnt(0));
    wd(0);
    ticks(1);
    wd(1);
    stop <= 1'b0;
    apb(1'b1, wdp_pkg::OFS_MODE, 32'h60, 1'b0);
    wd(1);
    repeat (4) begin
      k = 8'($urandom);
      if (k == wdp_pkg::KEY_VAL) k = 8'h00;
      apb(1'b1, wdp_pkg::OFS_KEY, {24'h0, k}, 1'b0);
      wd(1);
    end
    apb(1'b1, wdp_pkg::OFS_KEY, 32'hac, 1'b1);
    wd(1);
    print_verdict();
  end
endmodule // wdp_top_tb_top
